// File: hdl/olc_otp_lock_ctrl.sv
`timescale 1ns/100ps

// Contract
// [RULE1] Lock commands work during erase suspend
// [RULE2] Host suspends and polls ready and suspended
// [RULE3] Host resumes erase after lock changes
// [RULE4] Bad confirm after lock setup flags error
// [RULE5] Sequence error survives erase resume
// [RULE6] Same block lock immediate, erase completes
// [RULE7] No lock changes during program suspend
// [RULE8] Four areas selectable as one-time programmable
// [RULE9] Host drives upper address high, top parts
// [RULE10] Seventeen independently lockable secure registers
// [RULE11] First register: factory number plus user half
// [RULE12] Secure bits never erase, repeat programming
// [RULE13] Identifier mode reads one word each
// [RULE14] Command then data, one word programmed
// [RULE15] Out of range program sets program error
// [RULE16] Locked register program sets program, lock
// [RULE17] Lock words live at 0x80 and 0x89
// [RULE18] Lock word zero bit0 factory, bit1 user
// [RULE19] Lock word one bits lock upper registers
// [RULE20] Lock bits one-time, never unlock
// [RULE21] Page mode non-array: first word only valid
// [RULE22] Burst non-array: same word every edge
// [RULE23] Ready bit low while busy
// [RULE24] Clear and reset clear sticky error bits
// [RULE25] Lock bit reads one until programmed; here lock word zero bit 0 resets to zero
module olc_otp_lock_ctrl #(
  parameter int ADDR_W = 12, // Word address width
  parameter int BLK_SHIFT = 9, // Address bits inside a block
  parameter bit TOP_CFG = 1'b0, // Parameter blocks at the top
  parameter int ERASE_CYCLES = olc_pkg::ERASE_CYCLES_DEF, // Erase time
  parameter int PROG_CYCLES = olc_pkg::PROG_CYCLES_DEF, // Program time
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF, // Arbitrary
  parameter logic [15:0] MFR_CODE = 16'h00A5, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h005A // Arbitrary value
) (
  input wire logic sys_clk_in, // System clock
  input wire logic reset_in, // Synchronous reset, high
  input wire logic clk_en_in, // Clock enable, freezes state
  input wire logic wr_in, // Command or data write strobe
  input wire logic [ADDR_W-1:0] wr_addr_in, // Write address
  input wire logic [15:0] wr_data_in, // Write data
  input wire logic rd_in, // Single read strobe
  input wire logic [ADDR_W-1:0] rd_addr_in, // Read address
  input wire logic rd_beat_in, // Later word of a page read
  input wire logic burst_start_in, // Burst read start
  input wire logic burst_edge_in, // Burst clock edge
  input wire logic [1:0] burst_len_in, // Burst length code
  input wire logic wp_n_in, // Write protect, low active
  input wire logic vpp_ok_in, // Program supply in range
  input wire logic [3:0] otp_area_set_in, // Make area one-time only
  input wire logic [15:0] array_data_in, // Main array read data
  output logic [15:0] rd_data_out, // Read data
  output logic rd_valid_out, // Read data valid pulse
  output logic burst_active_out, // Burst in progress
  output logic [7:0] status_word_out, // Status word
  output logic [(1<<(ADDR_W-BLK_SHIFT))-1:0] block_locked_out, // Locks
  output logic [3:0] otp_area_out // One-time-programmable areas
);
  import olc_pkg::*;

  localparam int NB_W = ADDR_W - BLK_SHIFT;
  localparam int NB = 1 << NB_W;
  localparam logic [CNT_W-1:0] ECNT = CNT_W'(ERASE_CYCLES);
  localparam logic [CNT_W-1:0] PCNT = CNT_W'(PROG_CYCLES);

  if (BLK_SHIFT < 9 || NB_W < 3 || ERASE_CYCLES < 1 ||
      PROG_CYCLES < 1 || ERASE_CYCLES >= (1 << CNT_W) ||
      PROG_CYCLES >= (1 << CNT_W)) begin : g_bad_param
    $error("olc_otp_lock_ctrl: unsupported parameter values");
  end

  // ----
  // Helper functions
  // ----
  // Offset lies on a secure register data word
  function automatic logic pr_hit(input logic [8:0] ofs);
    pr_hit = (ofs >= OFS_PR0 && ofs < OFS_LOCK1) ||
             (ofs >= OFS_PR1 && ofs <= OFS_PR_END);
  endfunction : pr_hit

  // Offset to linear secure word index
  function automatic logic [7:0] pr_index(input logic [8:0] ofs);
    logic [8:0] d;
    d = (ofs < OFS_LOCK1) ? ofs - OFS_PR0 : ofs - OFS_PR1 + {1'b0, PR_WORDS};
    pr_index = d[7:0];
  endfunction : pr_index

  // Lock bit that guards a secure word, cleared bit means locked
  function automatic logic pr_locked(input logic [7:0] idx,
      input logic [15:0] l0, input logic [15:0] l1);
    logic [7:0] r;
    r = idx - PR_WORDS;
    if (idx < PR_HALF) pr_locked = !l0[LK0_UID_BIT];
    else if (idx < PR_WORDS) pr_locked = !l0[LK0_USER_BIT];
    else pr_locked = !l1[r[6:3]];
  endfunction : pr_locked

  // Area membership of a block, mirrored for top configuration
  function automatic logic [3:0] blk_area(input logic [NB_W-1:0] blk);
    logic [NB_W-1:0] m;
    m = TOP_CFG ? ~blk : blk;
    blk_area = 4'h0;
    if (m < NB_W'(AREA_PARAM_BLOCKS)) blk_area[0] = 1'b1;
    else if (m < NB_W'(AREA_PARAM_BLOCKS + AREA_MAIN_BLOCKS))
      blk_area[2'(m[1:0] + 2'h1)] = 1'b1;
  endfunction : blk_area

  // Burst limit in beats, zero for continuous
  function automatic logic [4:0] burst_limit(input logic [1:0] code);
    burst_limit = (code == BL_CONT) ? 5'h00 : 5'(5'h04 << code);
  endfunction : burst_limit

  // ----
  // State
  // ----
  olc_cmd_state_type cs_q, cs_d;
  olc_wsm_type wsm_q, wsm_d;
  olc_read_mode_type mode_q, mode_d;
  logic [7:0] err_q, err_d, err_set;
  logic clr;
  logic [NB-1:0] lock_q, lock_d, ldn_q, ldn_d;
  logic [15:0] lk0_q, lk0_d, lk1_q, lk1_d;
  logic [NB_W-1:0] eblk_q, eblk_d;
  logic held_q, held_d;
  logic [7:0] pidx_q, pidx_d;
  logic [15:0] pdat_q, pdat_d;
  logic [CNT_W-1:0] ecnt_q, ecnt_d, pcnt_q, pcnt_d;
  logic [3:0] area_q;
  logic [7:0] sw;
  logic s1_valid_q, s1_pr_q, s1_bad_q, s1_burst_q;
  logic [15:0] s1_word_q;
  logic burst_q, burst_arr_q;
  logic [4:0] beats_q, blim_q;
  logic [15:0] mem_rdata;

  // ----
  // Decode
  // ----
  // Write side fields
  wire [7:0] cmd = wr_data_in[7:0];
  wire [NB_W-1:0] wr_blk = wr_addr_in[ADDR_W-1:BLK_SHIFT];
  wire [8:0] wr_ofs = wr_addr_in[8:0];
  wire wr_prot = lock_q[wr_blk] | (|(blk_area(wr_blk) & area_q)); // RULE8
  wire busy = wsm_q == WS_ERASE || wsm_q == WS_PROG ||
              wsm_q == WS_PR_READ || wsm_q == WS_PR_WRITE;

  // Read side fields
  wire [8:0] rd_ofs = rd_addr_in[8:0];
  wire [NB_W-1:0] rd_blk = rd_addr_in[ADDR_W-1:BLK_SHIFT];
  wire [7:0] rd_pidx = pr_index(rd_ofs);
  wire rd_req = rd_in | burst_start_in;
  wire rd_is_pr = mode_q == RM_ID && pr_hit(rd_ofs) && rd_pidx >= PR_HALF;
  wire rd_bad = rd_in & rd_beat_in & (mode_q != RM_ARRAY); // RULE21
  wire [15:0] uid_word = UNIQUE_ID[{rd_pidx[1:0], 4'h0} +: 16]; // RULE11

  // Identifier space word, lock words read one until programmed, except lock word zero bit 0, which resets to zero
  wire [15:0] id_word =
    (rd_ofs == OFS_MFR) ? MFR_CODE :
    (rd_ofs == OFS_DEVID) ? DEV_CODE :
    (rd_ofs == OFS_BLK_LOCK) ? {14'h0000, ldn_q[rd_blk], lock_q[rd_blk]} :
    (rd_ofs == OFS_LOCK0) ? lk0_q : // RULE17 RULE25
    (rd_ofs == OFS_LOCK1) ? lk1_q :
    pr_hit(rd_ofs) ? uid_word : UNDEF_WORD; // RULE13

  wire [15:0] imm_word = (mode_q == RM_ARRAY) ? array_data_in :
                         (mode_q == RM_STATUS) ? {8'h00, sw} : id_word;

  // Secure memory port, sequencer has priority over reads
  wire pr_busy = wsm_q == WS_PR_READ || wsm_q == WS_PR_WRITE;
  wire [7:0] mem_addr = pr_busy ? pidx_q : rd_pidx;
  wire mem_we = wsm_q == WS_PR_WRITE;
  wire [15:0] mem_wdata = mem_rdata & pdat_q; // RULE12

  // Status word: sticky errors plus live sequencer bits
  always_comb begin
    sw = err_q & STICKY_MASK;
    sw[SR_READY] = !busy; // RULE23
    sw[SR_ESUSP] = held_q & !busy;
    sw[SR_PSUSP] = wsm_q == WS_PSUSP;
  end

  // ----
  // Command decoder and write state machine
  // ----
  always_comb begin
    cs_d = cs_q;
    wsm_d = wsm_q;
    mode_d = mode_q;
    err_set = 8'h00;
    clr = 1'b0;
    lock_d = lock_q;
    ldn_d = ldn_q;
    lk0_d = lk0_q;
    lk1_d = lk1_q;
    eblk_d = eblk_q;
    held_d = held_q;
    pidx_d = pidx_q;
    pdat_d = pdat_q;
    ecnt_d = ecnt_q;
    pcnt_d = pcnt_q;
    // Internal progress of running operations
    unique case (wsm_q)
      WS_ERASE: begin
        if (ecnt_q == 1) wsm_d = WS_READY; // RULE6
        else ecnt_d = ecnt_q - 1'b1;
      end
      WS_PROG: begin
        if (pcnt_q == 1) wsm_d = held_q ? WS_ESUSP : WS_READY;
        else pcnt_d = pcnt_q - 1'b1;
      end
      WS_PR_READ: wsm_d = WS_PR_WRITE;
      WS_PR_WRITE: wsm_d = held_q ? WS_ESUSP : WS_READY;
      WS_READY, WS_ESUSP, WS_PSUSP: ;
    endcase
    if (wr_in) begin
      unique case (cs_q)
        CS_IDLE: begin
          if (busy) begin
            if (cmd == CMD_SUSPEND && wsm_q == WS_ERASE) begin
              wsm_d = WS_ESUSP;
              held_d = 1'b1;
            end else if (cmd == CMD_SUSPEND && wsm_q == WS_PROG) begin
              wsm_d = WS_PSUSP;
            end
            if (cmd == CMD_READ_STATUS) mode_d = RM_STATUS;
          end else begin
            case (cmd)
              CMD_READ_ARRAY: mode_d = RM_ARRAY;
              CMD_READ_STATUS: mode_d = RM_STATUS;
              CMD_READ_ID: mode_d = RM_ID; // RULE13
              CMD_CLEAR_STATUS: clr = 1'b1; // RULE24
              CMD_ERASE_SETUP: if (wsm_q == WS_READY) cs_d = CS_ERASE;
              CMD_PROG: if (wsm_q != WS_PSUSP) cs_d = CS_PROG;
              CMD_LOCK_SETUP: cs_d = CS_LOCK;
              CMD_PR_PROG: if (wsm_q != WS_PSUSP) cs_d = CS_PR; // RULE14
              CMD_CONFIRM: begin
                // Resume keeps sticky errors intact
                if (wsm_q == WS_PSUSP) wsm_d = WS_PROG;
                else if (wsm_q == WS_ESUSP) begin
                  wsm_d = WS_ERASE; // RULE5
                  held_d = 1'b0;
                end
              end
              default: ;
            endcase
            if (cmd == CMD_ERASE_SETUP || cmd == CMD_PROG ||
                cmd == CMD_LOCK_SETUP || cmd == CMD_PR_PROG)
              mode_d = RM_STATUS;
          end
        end
        CS_LOCK: begin
          cs_d = CS_IDLE;
          if (cmd == CMD_LOCK || cmd == CMD_CONFIRM ||
              cmd == CMD_LOCKDOWN) begin
            if (wsm_q == WS_PSUSP) err_set = ERR_SEQ; // RULE7
            else if (cmd == CMD_LOCK) lock_d[wr_blk] = 1'b1; // RULE1
            else if (cmd == CMD_LOCKDOWN) begin
              lock_d[wr_blk] = 1'b1; // RULE6
              ldn_d[wr_blk] = 1'b1;
            end else if (!ldn_q[wr_blk] || wp_n_in) begin
              lock_d[wr_blk] = 1'b0; // RULE1
            end
          end else begin
            err_set = ERR_SEQ; // RULE4
          end
        end
        CS_ERASE: begin
          cs_d = CS_IDLE;
          if (cmd != CMD_CONFIRM) err_set = ERR_SEQ;
          else if (wr_prot) err_set = ERR_ERASE_LOCK; // RULE8
          else if (!vpp_ok_in) err_set = ERR_ERASE_VPP;
          else begin
            wsm_d = WS_ERASE;
            eblk_d = wr_blk;
            ecnt_d = ECNT;
          end
        end
        CS_PROG: begin
          cs_d = CS_IDLE;
          if (wr_prot) err_set = ERR_PROG_LOCK; // RULE8
          else if (held_q && wr_blk == eblk_q) err_set = ERR_SEQ;
          else if (!vpp_ok_in) err_set = ERR_PROG_VPP;
          else begin
            wsm_d = WS_PROG;
            pcnt_d = PCNT;
          end
        end
        CS_PR: begin
          cs_d = CS_IDLE;
          if (wr_ofs == OFS_LOCK0) lk0_d = lk0_q & wr_data_in; // RULE18
          else if (wr_ofs == OFS_LOCK1)
            lk1_d = lk1_q & wr_data_in; // RULE19 RULE20
          else if (!pr_hit(wr_ofs)) err_set = ERR_PROG; // RULE15
          else if (pr_locked(pr_index(wr_ofs), lk0_q, lk1_q))
            err_set = ERR_PROG_LOCK; // RULE16 RULE10
          else if (!vpp_ok_in) err_set = ERR_PROG_VPP;
          else begin
            pidx_d = pr_index(wr_ofs); // RULE14
            pdat_d = wr_data_in;
            wsm_d = WS_PR_READ;
          end
        end
      endcase
    end
  end

  // Sticky errors: a set in the clearing cycle wins
  assign err_d = ((clr ? 8'h00 : err_q) | err_set) & STICKY_MASK; // RULE24

  // ----
  // Registers
  // ----
  // Command, sequencer and protection state
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cs_q <= CS_IDLE;
      wsm_q <= WS_READY;
      mode_q <= RM_ARRAY;
      err_q <= 8'h00; // RULE24
      lock_q <= '1;
      ldn_q <= '0;
      lk0_q <= LOCK0_RESET; // RULE18
      lk1_q <= LOCK1_RESET;
      eblk_q <= '0;
      held_q <= 1'b0;
      pidx_q <= 8'h00;
      pdat_q <= BLANK_WORD;
      ecnt_q <= '0;
      pcnt_q <= '0;
      area_q <= 4'h0;
      status_word_out <= 8'h00;
    end else if (clk_en_in) begin
      cs_q <= cs_d;
      wsm_q <= wsm_d;
      mode_q <= mode_d;
      err_q <= err_d;
      lock_q <= lock_d;
      ldn_q <= ldn_d;
      lk0_q <= lk0_d;
      lk1_q <= lk1_d;
      eblk_q <= eblk_d;
      held_q <= held_d;
      pidx_q <= pidx_d;
      pdat_q <= pdat_d;
      ecnt_q <= ecnt_d;
      pcnt_q <= pcnt_d;
      area_q <= area_q | otp_area_set_in; // RULE8
      status_word_out <= sw;
    end
  end

  // Read stage one: capture selection and immediate word
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s1_valid_q <= 1'b0;
      s1_pr_q <= 1'b0;
      s1_bad_q <= 1'b0;
      s1_burst_q <= 1'b0;
      s1_word_q <= UNDEF_WORD;
    end else if (clk_en_in) begin
      s1_valid_q <= rd_req;
      s1_pr_q <= rd_is_pr;
      s1_bad_q <= rd_bad;
      s1_burst_q <= burst_start_in;
      s1_word_q <= imm_word;
    end
  end

  // Read stage two and burst beats
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rd_data_out <= UNDEF_WORD;
      rd_valid_out <= 1'b0;
      burst_q <= 1'b0;
      burst_arr_q <= 1'b0;
      beats_q <= 5'h00;
      blim_q <= 5'h00;
    end else if (clk_en_in) begin
      rd_valid_out <= 1'b0;
      if (burst_start_in) begin
        burst_q <= 1'b1;
        burst_arr_q <= mode_q == RM_ARRAY;
        blim_q <= burst_limit(burst_len_in);
        beats_q <= 5'h00;
      end else if (s1_valid_q) begin
        rd_data_out <= s1_bad_q ? UNDEF_WORD :
                       s1_pr_q ? mem_rdata : s1_word_q; // RULE21
        rd_valid_out <= !s1_bad_q;
        if (s1_burst_q) beats_q <= 5'h01;
        if (s1_burst_q && blim_q == 5'h01) burst_q <= 1'b0;
      end else if (burst_q && burst_edge_in) begin
        // Non-array data repeats, array data follows the array
        if (burst_arr_q) rd_data_out <= array_data_in;
        rd_valid_out <= 1'b1; // RULE22
        beats_q <= beats_q + 5'h01;
        if (beats_q + 5'h01 == blim_q) burst_q <= 1'b0; // RULE22
      end
    end
  end

  // ----
  // Secure register storage
  // ----
  olc_otp_mem #(
    .WIDTH(16),
    .DEPTH(PR_DEPTH),
    .AW(8)
  ) u_mem (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .wr_en_in(mem_we),
    .addr_in(mem_addr),
    .wr_data_in(mem_wdata),
    .rd_data_out(mem_rdata)
  );

  // Outputs straight from state registers
  assign burst_active_out = burst_q;
  assign block_locked_out = lock_q;
  assign otp_area_out = area_q;

endmodule : olc_otp_lock_ctrl

// File: hdl/olc_pkg.sv
package olc_pkg;

  // ----
  // Command codes (low byte of a bus write)
  // ----
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN = 8'h2F;
  localparam logic [7:0] CMD_PR_PROG = 8'hC0;

  // ----
  // Status word fields and error patterns
  // ----
  localparam int SR_READY = 7;
  localparam int SR_ESUSP = 6;
  localparam int SR_PSUSP = 2;
  localparam logic [7:0] STICKY_MASK = 8'h3A;
  localparam logic [7:0] ERR_SEQ = 8'h30;
  localparam logic [7:0] ERR_ERASE_LOCK = 8'h22;
  localparam logic [7:0] ERR_ERASE_VPP = 8'h28;
  localparam logic [7:0] ERR_PROG = 8'h10;
  localparam logic [7:0] ERR_PROG_LOCK = 8'h12;
  localparam logic [7:0] ERR_PROG_VPP = 8'h18;

  // ----
  // Identifier space offsets (low nine address bits)
  // ----
  localparam logic [8:0] OFS_MFR = 9'h000;
  localparam logic [8:0] OFS_DEVID = 9'h001;
  localparam logic [8:0] OFS_BLK_LOCK = 9'h002;
  localparam logic [8:0] OFS_LOCK0 = 9'h080;
  localparam logic [8:0] OFS_PR0 = 9'h081;
  localparam logic [8:0] OFS_LOCK1 = 9'h089;
  localparam logic [8:0] OFS_PR1 = 9'h08A;
  localparam logic [8:0] OFS_PR_END = 9'h109;

  // ----
  // Secure register geometry and reset values
  // ----
  localparam int PR_DEPTH = 136;
  localparam logic [7:0] PR_HALF = 8'h04;
  localparam logic [7:0] PR_WORDS = 8'h08;
  localparam int LK0_UID_BIT = 0;
  localparam int LK0_USER_BIT = 1;
  localparam logic [15:0] LOCK0_RESET = 16'hFFFE;
  localparam logic [15:0] LOCK1_RESET = 16'hFFFF;
  localparam logic [15:0] BLANK_WORD = 16'hFFFF;
  localparam logic [15:0] UNDEF_WORD = 16'h0000;

  // ----
  // One-time-programmable areas, burst lengths, timing
  // ----
  localparam int AREA_PARAM_BLOCKS = 4;
  localparam int AREA_MAIN_BLOCKS = 3;
  localparam logic [1:0] BL_CONT = 2'h3;
  localparam int CNT_W = 16;
  localparam int ERASE_CYCLES_DEF = 64;
  localparam int PROG_CYCLES_DEF = 16;

  typedef enum logic [2:0] {
    CS_IDLE, CS_LOCK, CS_ERASE, CS_PROG, CS_PR
  } olc_cmd_state_type;

  typedef enum logic [2:0] {
    WS_READY, WS_ERASE, WS_ESUSP, WS_PROG, WS_PSUSP, WS_PR_READ,
    WS_PR_WRITE
  } olc_wsm_type;

  typedef enum logic [1:0] {
    RM_ARRAY, RM_STATUS, RM_ID
  } olc_read_mode_type;

endpackage : olc_pkg

// File: hdl/olc_otp_mem.sv
`timescale 1ns/100ps

module olc_otp_mem #(
  parameter int WIDTH = 16, // Word width
  parameter int DEPTH = 136, // Number of words
  parameter int AW = 8 // Address width
) (
  input wire logic sys_clk_in, // System clock
  input wire logic reset_in, // Synchronous reset, high
  input wire logic clk_en_in, // Clock enable
  input wire logic wr_en_in, // Write strobe
  input wire logic [AW-1:0] addr_in, // Word address
  input wire logic [WIDTH-1:0] wr_data_in, // Write data
  output logic [WIDTH-1:0] rd_data_out // Registered read data
);

  if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
    $error("olc_otp_mem: depth does not fit the address width");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Storage: blank (all ones) after reset, read data registered
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= {WIDTH{1'b1}};
      end
      rd_data_out <= {WIDTH{1'b1}};
    end else if (clk_en_in) begin
      if (wr_en_in) begin
        mem_q[addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_q[addr_in];
    end
  end

endmodule : olc_otp_mem

// File: tb/olc_otp_lock_ctrl_assertions.sv
`timescale 1ns/100ps
module olc_chk import olc_pkg::*; #(
  parameter int ADDR_W = 12, // Width
  parameter int BLK_SHIFT = 9 // Block
) (
  input wire logic sys_clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic wr_in, // Write
  input wire logic [ADDR_W-1:0] wr_addr_in, // Address
  input wire logic [15:0] wr_data_in, // Data
  input wire logic rd_in, // Read
  input wire logic rd_beat_in, // Beat
  input wire logic wp_n_in, // Protect
  input wire logic [3:0] otp_area_set_in, // Area set
  input wire logic rd_valid_out, // Valid
  input wire logic [7:0] status_word_out, // Status
  input wire logic [(1<<(ADDR_W-BLK_SHIFT))-1:0] block_locked_out, // Locks
  input wire logic [3:0] otp_area_out // Areas
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  // Command byte, block, idle and clear decode
  wire logic [7:0] cmd = wr_data_in[7:0];
  wire logic [ADDR_W-BLK_SHIFT-1:0] blk = wr_addr_in[ADDR_W-1:BLK_SHIFT];
  wire logic rdy = status_word_out[7] && !status_word_out[2];
  wire logic clr = wr_in && cmd == CMD_CLEAR_STATUS;
  wire logic good = cmd inside {CMD_LOCK, CMD_LOCKDOWN, CMD_CONFIRM};
  // Lock setup and its confirm steps
  sequence s_setup;
    wr_in && cmd == CMD_LOCK_SETUP && rdy ##1 !wr_in;
  endsequence
  sequence s_lock;
    wr_in && (cmd == CMD_LOCK || cmd == CMD_LOCKDOWN);
  endsequence
  sequence s_unlock;
    wr_in && cmd == CMD_CONFIRM && wp_n_in;
  endsequence
  // Checks
  a_read_latency: assert property (rd_in && !rd_beat_in |-> ##2 rd_valid_out)
    else $error("read answer late");
  a_reset_state: assert property (disable iff (1'b0) reset_in |=>
    status_word_out == 8'h00 && &block_locked_out && otp_area_out == 4'h0)
    else $error("reset state wrong");
  a_lock_set: assert property (s_setup ##1 s_lock |=>
    block_locked_out[$past(blk)]) else $error("lock missed");
  a_unlock_clear: assert property (s_setup ##1 s_unlock |=>
    !block_locked_out[$past(blk)]) else $error("unlock missed");
  a_bad_confirm: assert property (s_setup ##1 (wr_in && !good) |->
    ##[1:3] status_word_out[5:4] == 2'b11)
    else $error("sequence error missing");
  a_sticky_err: assert property (!$past(reset_in) &&
    ($fell(status_word_out[4]) || $fell(status_word_out[5])) |->
    $past(clr) || $past(clr, 2) || $past(clr, 3))
    else $error("error bit cleared alone");
  a_busy_bounded: assert property ($fell(status_word_out[7]) |->
    ##[1:40] status_word_out[7]) else $error("busy too long");
  a_area_set: assert property (otp_area_set_in != 4'h0 |=>
    (otp_area_out & $past(otp_area_set_in)) == $past(otp_area_set_in))
    else $error("area not set");
  a_area_hold: assert property (!$past(reset_in) |->
    (otp_area_out & $past(otp_area_out)) == $past(otp_area_out))
    else $error("area dropped");
endmodule : olc_chk

bind olc_otp_lock_ctrl olc_chk #(.ADDR_W(ADDR_W), .BLK_SHIFT(BLK_SHIFT))
  i_chk (.sys_clk_in, .reset_in, .wr_in, .wr_addr_in, .wr_data_in, .rd_in,
  .rd_beat_in, .wp_n_in, .otp_area_set_in, .rd_valid_out, .status_word_out,
  .block_locked_out, .otp_area_out);

// File: tb/olc_host.sv
`timescale 1ns/100ps
module olc_host import olc_pkg::*; (
  input wire logic sys_clk_in, // Clock
  input wire logic valid_in, // Read valid
  input wire logic [15:0] rdata_in, // Read data
  output logic wr_out = 1'b0, // Write strobe
  output logic [11:0] waddr_out = 12'h000, // Write address
  output logic [15:0] wdata_out = 16'h0000, // Write data
  output logic rd_out = 1'b0, // Read strobe
  output logic beat_out = 1'b0, // Page beat
  output logic [11:0] raddr_out = 12'h000 // Read address
);
  logic [15:0] q; // Last word read
  logic v; // Last valid seen
  // One write, held until the taking edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    wr_out <= 1'b1;
    waddr_out <= a;
    wdata_out <= d;
    @(posedge sys_clk_in);
    wr_out <= 1'b0;
  endtask : wr
  // Command byte write
  task automatic cm(input logic [11:0] a, input logic [7:0] c);
    wr(a, {8'h00, c});
  endtask : cm
  // Read, data one edge after taking
  task automatic rd(input logic [11:0] a, input logic b);
    @(posedge sys_clk_in);
    rd_out <= 1'b1;
    beat_out <= b;
    raddr_out <= a;
    @(posedge sys_clk_in);
    rd_out <= 1'b0;
    beat_out <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    v = valid_in;
    q = rdata_in;
  endtask : rd
  // Poll status until all mask bits are set
  task automatic poll(input logic [7:0] m);
    int n = 0;
    cm(12'h000, CMD_READ_STATUS);
    do begin
      rd(12'h000, 1'b0);
      n++;
    end while ((q[7:0] & m) != m && n < 50);
  endtask : poll
  // Secure word program: command and data at one address
  task automatic prg(input logic [11:0] a, input logic [15:0] d);
    cm(a, CMD_PR_PROG);
    wr(a, d);
    poll(8'h80);
  endtask : prg
endmodule : olc_host

// File: tb/olc_otp_lock_ctrl_tb.sv
`timescale 1ns/100ps
module olc_otp_lock_ctrl_tb;
  import olc_pkg::*;
  typedef struct {logic [11:0] a; logic [15:0] e;} olc_row_type;
  localparam logic [63:0] UID = 64'h1122_3344_5566_7788; // Arbitrary
  logic clk = 1'b0, rst = 1'b1, bs = 1'b0, be = 1'b0;
  logic [3:0] oas = 4'h0;
  logic ce = 1'b1, wp = 1'b1, vpp = 1'b1;
  logic wr, rd, beat, vld, bact;
  logic [11:0] wa, ra;
  logic [15:0] wd, rdat;
  logic [7:0] sw, lk;
  logic [3:0] oarea;
  int fails = 0, comparisons = 0, cyc = 0, n;
  olc_row_type rows [7] = '{'{12'h000, 16'h1234}, '{12'h080, 16'hFFFE},
    '{12'h089, 16'hFFFF}, '{12'h081, UID[15:0]}, '{12'h084, UID[63:48]},
    '{12'h085, 16'hFFFF}, '{12'h109, 16'hFFFF}};
  // Clock and hang guard
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  olc_otp_lock_ctrl #(.ERASE_CYCLES(4), .PROG_CYCLES(3), .UNIQUE_ID(UID),
    .MFR_CODE(16'h1234)) i_dut (.sys_clk_in(clk), .reset_in(rst),
    .clk_en_in(ce), .wr_in(wr), .wr_addr_in(wa), .wr_data_in(wd),
    .rd_in(rd), .rd_addr_in(ra), .rd_beat_in(beat), .burst_start_in(bs),
    .burst_edge_in(be), .burst_len_in(2'h0), .wp_n_in(wp),
    .vpp_ok_in(vpp), .otp_area_set_in(oas), .array_data_in(16'h5555),
    .rd_data_out(rdat), .rd_valid_out(vld), .burst_active_out(bact),
    .status_word_out(sw), .block_locked_out(lk), .otp_area_out(oarea));
  olc_host h (.sys_clk_in(clk), .valid_in(vld), .rdata_in(rdat),
    .wr_out(wr), .waddr_out(wa), .wdata_out(wd), .rd_out(rd),
    .beat_out(beat), .raddr_out(ra));
  // Compare and count
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic rchk(input logic [11:0] a, input logic [15:0] e);
    h.rd(a, 1'b0);
    chk(h.q, e);
  endtask : rchk
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    h.cm(12'h000, CMD_READ_ID);
    foreach (rows[i]) rchk(rows[i].a, rows[i].e);
    $display("identifier rows done");
    h.prg(12'h08A, 16'hFF0F);
    h.prg(12'h08A, 16'hF0FF);
    h.prg(12'h089, 16'hFFFE);
    h.prg(12'h08A, 16'h0000);
    chk(h.q, 16'h0092);
    h.cm(12'h000, CMD_CLEAR_STATUS);
    h.prg(12'h110, 16'h0000);
    chk(h.q, 16'h0090);
    h.cm(12'h000, CMD_CLEAR_STATUS);
    h.prg(12'h089, 16'hFFFF);
    h.prg(12'h080, 16'hFFFD);
    h.cm(12'h000, CMD_READ_ID);
    rchk(12'h08A, 16'hF00F);
    rchk(12'h089, 16'hFFFE);
    rchk(12'h080, 16'hFFFC);
    @(posedge clk) vpp <= 1'b0;
    h.prg(12'h092, 16'h0000);
    chk(h.q, 16'h0098);
    @(posedge clk) vpp <= 1'b1;
    $display("secure registers done");
    h.cm(12'h000, CMD_CLEAR_STATUS);
    h.cm(12'h400, CMD_LOCK_SETUP);
    h.cm(12'h400, CMD_CONFIRM);
    h.cm(12'h400, CMD_ERASE_SETUP);
    h.cm(12'h400, CMD_CONFIRM);
    h.cm(12'h000, CMD_SUSPEND);
    h.poll(8'hC0);
    h.cm(12'h400, CMD_LOCK_SETUP);
    h.cm(12'h400, CMD_LOCK);
    @(posedge clk);
    #1;
    chk(16'(lk[2]), 16'h0001);
    h.cm(12'h400, CMD_LOCK_SETUP);
    h.cm(12'h400, CMD_READ_ARRAY);
    h.cm(12'h000, CMD_CONFIRM);
    h.poll(8'h80);
    chk(h.q, 16'h00B0);
    $display("erase suspend done");
    h.rd(12'h000, 1'b1);
    chk(16'(h.v), 16'h0000);
    chk(h.q, 16'h0000);
    @(posedge clk) bs <= 1'b1;
    @(posedge clk) bs <= 1'b0;
    n = 0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      be <= (i > 2) && (i < 9) && i[0];
      #1;
      if (vld === 1'b1) begin
        n++;
        chk(rdat, 16'h00B0);
      end
    end
    chk({bact, 15'(n)}, 16'h0004);
    $display("page and burst done");
    @(posedge clk) oas <= 4'h1;
    @(posedge clk) oas <= 4'h0;
    @(posedge clk) ce <= 1'b0;
    h.cm(12'h000, CMD_CLEAR_STATUS);
    @(posedge clk) ce <= 1'b1;
    h.cm(12'h000, CMD_LOCK_SETUP);
    h.cm(12'h000, CMD_CONFIRM);
    h.cm(12'h000, CMD_ERASE_SETUP);
    h.cm(12'h000, CMD_CONFIRM);
    h.poll(8'h80);
    chk(h.q, 16'h00B2);
    @(posedge clk) wp <= 1'b0;
    h.cm(12'h600, CMD_LOCK_SETUP);
    h.cm(12'h600, CMD_LOCKDOWN);
    h.cm(12'h600, CMD_LOCK_SETUP);
    h.cm(12'h600, CMD_CONFIRM);
    #1;
    chk(16'(lk[3]), 16'h0001);
    @(posedge clk) rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({lk, 4'h0, oarea}, 16'hFF00);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(sw), 16'h0080);
    $display("area and reset done");
    results();
  end
endmodule : olc_otp_lock_ctrl_tb
